// ===== verilog/bp_debug_pkg.sv
// Constants for breakpoint comparison and debug entry logic.
// Assumes a 16-bit core address space and 16-bit register writes.
package bp_debug_pkg;
	localparam logic [15:0] BP_RESET = 16'hFFFF;
	localparam logic [15:0] DEBUG_ENTRY_ADDR = 16'h8010;
	localparam logic [7:0] OP_READ_CTRL = 8'h01;
	localparam logic [7:0] OP_READ_MASK = 8'h03;
	localparam logic [7:0] OP_READ_DATA = 8'h04;
	localparam logic [7:0] OP_READ_BP0 = 8'h05;
	localparam logic [7:0] OP_READ_BP5 = 8'h0A;
	localparam logic [7:0] OP_WRITE_CTRL = 8'h11;
	localparam logic [7:0] OP_WRITE_MASK = 8'h13;
	localparam logic [7:0] OP_WRITE_DATA = 8'h14;
	localparam logic [7:0] OP_WRITE_BP0 = 8'h15;
	localparam logic [7:0] OP_WRITE_BP5 = 8'h1A;
	localparam logic [7:0] OP_DEBUG = 8'h1F;
	localparam int BP_COUNT = 6;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_REGSEL_BIT = 1;
	localparam int MOD_LSB = 0;
	localparam int MOD_MSB = 3;
	localparam int IDX_LSB = 4;
	localparam int IDX_MSB = 8;
	localparam logic [1:0] STATUS_BACKGROUND = 2'h0;
	localparam logic [1:0] STATUS_DEBUG_IDLE = 2'h1;
	typedef enum logic [2:0] {ST_RUN, ST_WAIT, ST_BLOCK, ST_PUSH, ST_LOAD, ST_IGE, ST_HALT}
		entry_state_e;
endpackage : bp_debug_pkg

// ===== verilog/bp_cmd_if.sv
// Carries one decoded host command from the command port into the engine.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
interface bp_cmd_if;
	logic valid;
	logic [7:0] opcode;
	logic [15:0] data;
	modport src (output valid, output opcode, output data);
	modport dst (input valid, input opcode, input data);
endinterface : bp_cmd_if

// ===== verilog/bp_cmd_port.sv
// Host command port: samples the link clock, shifts 24-bit frames LSB first.
// Frame is opcode then data LSB first; data and frame pins pass two flip-flops, the link clock three.
`timescale 1ns/1ps
module bp_cmd_port (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic tck_i,
	input wire logic tdi_i,
	input wire logic frame_i,
	bp_cmd_if.src cmd
);
	typedef struct packed {
		logic [2:0] tck_s;
		logic [1:0] tdi_s;
		logic [1:0] frm_s;
		logic [23:0] shift;
		logic [4:0] cnt;
		logic valid;
		logic [7:0] opcode;
		logic [15:0] data;
	} port_s;
	port_s state_reg;
	port_s state_next;
	logic rise;
	always_comb
	begin
		state_next = state_reg;
		state_next.tck_s = {state_reg.tck_s[1:0], tck_i};
		state_next.tdi_s = {state_reg.tdi_s[0], tdi_i};
		state_next.frm_s = {state_reg.frm_s[0], frame_i};
		state_next.valid = 1'b0;
		// Edge seen only on synchronised copies
		rise = state_reg.tck_s[1] & ~state_reg.tck_s[2];
		if (!state_reg.frm_s[1])
		begin
			state_next.cnt = 5'h00;
		end
		else if (rise)
		begin
			state_next.shift = {state_reg.tdi_s[1], state_reg.shift[23:1]};
			state_next.cnt = state_reg.cnt + 5'h01;
			if (state_reg.cnt == 5'h17)
			begin
				state_next.valid = 1'b1;
				state_next.opcode = state_next.shift[7:0];
				state_next.data = state_next.shift[23:8];
				state_next.cnt = 5'h00;
			end
		end
	end
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end
	assign cmd.valid = state_reg.valid;
	assign cmd.opcode = state_reg.opcode;
	assign cmd.data = state_reg.data;
endmodule : bp_cmd_port

// ===== verilog/bp_debug_entry.sv
// Breakpoint compare and debug-mode entry sequencer of the debug engine.
// Assumes the core reports write and prefix activity in the clk_i domain.
// What this block does
// - Address mode: dual breakpoints compare data address bus and break on equality
// - Register mode: bits 3:0 module, 8:4 index, 15:9 ignored
// - In register mode the second dual breakpoint also needs masked written data to match
// - All breakpoints reset to FFFFh on power-on and test-logic-reset
// - Breakpoints reachable only through host commands, never by the CPU
// - Enable bit arms comparison on all six breakpoints
// - Select bit picks address or register matching for both dual breakpoints
// - Break on a prefix instruction waits until the prefixed op completes
// - Status reads 00b in background, 01b once in debug mode
// - Breakpoint or host debug command enter debug mode the same way
// - Entry: block fetch, push return, load 8010h, clear interrupt enable, halt
// - In debug mode further matches and debug commands do nothing
// - Debug mode stops every timer clock including watchdog
// - No interrupt granted in debug mode
// - Four program breakpoints compare with execution address when enabled
// - Host debug command halts after the current instruction completes
`timescale 1ns/1ps
module bp_debug_entry (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic tck_i,
	input wire logic tdi_i,
	input wire logic frame_i,
	input wire logic tap_reset_i,
	input wire logic [15:0] pc_i,
	input wire logic pc_valid_i,
	input wire logic [15:0] daddr_i,
	input wire logic daddr_valid_i,
	input wire logic [8:0] dest_i,
	input wire logic [15:0] wdata_i,
	input wire logic dest_valid_i,
	input wire logic prefix_i,
	input wire logic instr_done_i,
	output logic fetch_block_o,
	output logic push_ret_o,
	output logic ip_load_o,
	output logic [15:0] ip_value_o,
	output logic ige_clear_o,
	output logic cpu_halt_o,
	output logic timer_stop_o,
	output logic irq_block_o,
	output logic [1:0] status_o,
	output logic [15:0] rd_data_o,
	output logic rd_valid_o
);
	bp_cmd_if cmd_bus ();
	bp_cmd_port u_port (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.tck_i(tck_i),
		.tdi_i(tdi_i),
		.frame_i(frame_i),
		.cmd(cmd_bus)
	);
	typedef struct packed {
		logic [1:0] trst_s;
		logic [5:0][15:0] bp;
		logic [15:0] ctrl;
		logic [15:0] dbg_data;
		logic [15:0] dbg_mask;
		bp_debug_pkg::entry_state_e st;
		logic debug;
		logic fetch_block;
		logic push_ret;
		logic ip_load;
		logic ige_clear;
		logic halt;
		logic [15:0] rd_data;
		logic rd_valid;
		logic [15:0] ip_value;
		logic [1:0] status;
	} eng_s;
	eng_s state_reg;
	eng_s state_next;
	logic [5:0] hit;
	logic en;
	logic regsel;
	logic dest_match_a;
	logic dest_match_b;
	logic data_ok;
	logic [2:0] sel;
	assign en = state_reg.ctrl[bp_debug_pkg::CTRL_ENABLE_BIT];
	assign regsel = state_reg.ctrl[bp_debug_pkg::CTRL_REGSEL_BIT];
	assign dest_match_a = dest_i == state_reg.bp[4][bp_debug_pkg::IDX_MSB:0];
	assign dest_match_b = dest_i == state_reg.bp[5][bp_debug_pkg::IDX_MSB:0];
	assign data_ok = ((wdata_i ^ state_reg.dbg_data) & state_reg.dbg_mask) == 16'h0000;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_prog
			assign hit[gi] = en && pc_valid_i && pc_i == state_reg.bp[gi];
		end
	endgenerate
	// Gated by enable so a cleared bit never breaks
	assign hit[4] = en && (regsel ? (dest_valid_i && dest_match_a)
		: (daddr_valid_i && daddr_i == state_reg.bp[4]));
	assign hit[5] = en && (regsel ? (dest_valid_i && dest_match_b && data_ok)
		: (daddr_valid_i && daddr_i == state_reg.bp[5]));
	always_comb
	begin
		state_next = state_reg;
		state_next.trst_s = {state_reg.trst_s[0], tap_reset_i};
		state_next.fetch_block = 1'b0;
		state_next.push_ret = 1'b0;
		state_next.ip_load = 1'b0;
		state_next.ige_clear = 1'b0;
		state_next.rd_valid = 1'b0;
		sel = 3'h0;
		// Only host frames reach the registers; no CPU path exists
		if (cmd_bus.valid)
		begin
			if (cmd_bus.opcode == bp_debug_pkg::OP_WRITE_CTRL)
				state_next.ctrl = cmd_bus.data;
			if (cmd_bus.opcode == bp_debug_pkg::OP_WRITE_MASK)
				state_next.dbg_mask = cmd_bus.data;
			if (cmd_bus.opcode == bp_debug_pkg::OP_WRITE_DATA)
				state_next.dbg_data = cmd_bus.data;
			if (cmd_bus.opcode >= bp_debug_pkg::OP_WRITE_BP0
				&& cmd_bus.opcode <= bp_debug_pkg::OP_WRITE_BP5)
			begin
				sel = 3'(cmd_bus.opcode - bp_debug_pkg::OP_WRITE_BP0);
				state_next.bp[sel] = cmd_bus.data;
			end
			if (cmd_bus.opcode == bp_debug_pkg::OP_READ_CTRL)
			begin
				state_next.rd_data = state_reg.ctrl;
				state_next.rd_valid = 1'b1;
			end
			if (cmd_bus.opcode == bp_debug_pkg::OP_READ_MASK)
			begin
				state_next.rd_data = state_reg.dbg_mask;
				state_next.rd_valid = 1'b1;
			end
			if (cmd_bus.opcode == bp_debug_pkg::OP_READ_DATA)
			begin
				state_next.rd_data = state_reg.dbg_data;
				state_next.rd_valid = 1'b1;
			end
			if (cmd_bus.opcode >= bp_debug_pkg::OP_READ_BP0
				&& cmd_bus.opcode <= bp_debug_pkg::OP_READ_BP5)
			begin
				sel = 3'(cmd_bus.opcode - bp_debug_pkg::OP_READ_BP0);
				state_next.rd_data = state_reg.bp[sel];
				state_next.rd_valid = 1'b1;
			end
		end
		case (state_reg.st)
			bp_debug_pkg::ST_RUN:
			begin
				// Both entry paths share the same sequence
				if (|hit || (cmd_bus.valid && cmd_bus.opcode == bp_debug_pkg::OP_DEBUG))
					state_next.st = bp_debug_pkg::ST_WAIT;
			end
			bp_debug_pkg::ST_WAIT:
			begin
				// Prefix holds the break until the prefixed op finishes
				if (instr_done_i && !prefix_i)
				begin
					state_next.st = bp_debug_pkg::ST_BLOCK;
					state_next.fetch_block = 1'b1;
				end
			end
			bp_debug_pkg::ST_BLOCK:
			begin
				state_next.st = bp_debug_pkg::ST_PUSH;
				state_next.fetch_block = 1'b1;
				state_next.push_ret = 1'b1;
			end
			bp_debug_pkg::ST_PUSH:
			begin
				state_next.st = bp_debug_pkg::ST_LOAD;
				state_next.fetch_block = 1'b1;
				state_next.ip_load = 1'b1;
				state_next.ip_value = bp_debug_pkg::DEBUG_ENTRY_ADDR;
			end
			bp_debug_pkg::ST_LOAD:
			begin
				state_next.st = bp_debug_pkg::ST_IGE;
				state_next.fetch_block = 1'b1;
				state_next.ige_clear = 1'b1;
			end
			bp_debug_pkg::ST_IGE:
			begin
				state_next.st = bp_debug_pkg::ST_HALT;
				state_next.halt = 1'b1;
				state_next.debug = 1'b1;
				state_next.status = bp_debug_pkg::STATUS_DEBUG_IDLE;
			end
			bp_debug_pkg::ST_HALT:
			begin
				// Matches and repeated debug commands ignored here
				state_next.st = bp_debug_pkg::ST_HALT;
			end
			default:
				state_next.st = bp_debug_pkg::ST_RUN;
		endcase
		if (state_reg.trst_s[1])
			state_next.bp = {6{bp_debug_pkg::BP_RESET}};
	end
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_reg <= '0;
			state_reg.bp <= {6{bp_debug_pkg::BP_RESET}};
			state_reg.st <= bp_debug_pkg::ST_RUN;
		end
		else
			state_reg <= state_next;
	end
	assign fetch_block_o = state_reg.fetch_block;
	assign push_ret_o = state_reg.push_ret;
	assign ip_load_o = state_reg.ip_load;
	assign ip_value_o = state_reg.ip_value;
	assign ige_clear_o = state_reg.ige_clear;
	assign cpu_halt_o = state_reg.halt;
	assign timer_stop_o = state_reg.debug;
	assign irq_block_o = state_reg.debug;
	// Reset value of the status flop is the background code
	assign status_o = state_reg.status;
	assign rd_data_o = state_reg.rd_data;
	assign rd_valid_o = state_reg.rd_valid;
	AST_ENTRY_ORDER: assert property (@(posedge clk_i) disable iff (!rstn_i)
		push_ret_o |=> ip_load_o ##1 ige_clear_o ##1 cpu_halt_o)
		else $error("entry order wrong");
	AST_STATUS: assert property (@(posedge clk_i) disable iff (!rstn_i)
		status_o == (cpu_halt_o ? 2'h1 : 2'h0))
		else $error("status mismatch");
	AST_HALT_STAYS: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cpu_halt_o |=> cpu_halt_o && !push_ret_o)
		else $error("debug mode disturbed");
	AST_TIMERS: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(cpu_halt_o) |-> timer_stop_o && irq_block_o)
		else $error("timers run in debug");
	AST_IP: assert property (@(posedge clk_i) disable iff (!rstn_i)
		ip_load_o |-> ip_value_o == 16'h8010 && fetch_block_o)
		else $error("bad entry address");
	AST_NO_EN: assert property (@(posedge clk_i) disable iff (!rstn_i)
		state_reg.st == bp_debug_pkg::ST_RUN && !en
		&& !(cmd_bus.valid && cmd_bus.opcode == bp_debug_pkg::OP_DEBUG)
		|=> state_reg.st == bp_debug_pkg::ST_RUN)
		else $error("break while disabled");
	AST_PREFIX: assert property (@(posedge clk_i) disable iff (!rstn_i)
		state_reg.st == bp_debug_pkg::ST_WAIT && prefix_i |=> !fetch_block_o)
		else $error("break inside prefix");
	AST_BREAK: assert property (@(posedge clk_i) disable iff (!rstn_i)
		state_reg.st == bp_debug_pkg::ST_RUN && !regsel && en && daddr_valid_i
		&& daddr_i == state_reg.bp[4] |=> state_reg.st == bp_debug_pkg::ST_WAIT)
		else $error("address break missed");
	AST_TAP_RESET: assert property (@(posedge clk_i) disable iff (!rstn_i)
		state_reg.trst_s[1] |=> state_reg.bp[5] == 16'hFFFF)
		else $error("tap reset missed");
endmodule : bp_debug_entry

// ===== verif/host_link.sv
// Host model: sends command frames over the serial debug link.
// Assumes the block samples the link pins with its own clock.
`timescale 1ns/1ps
module host_link (
	output logic tck_o,
	output logic tdi_o,
	output logic frame_o
);
	initial
	begin
		tck_o = 1'b0;
		tdi_o = 1'b1;
		frame_o = 1'b0;
	end
	// Clock stands still between frames; idle data inverted so stale bits never pass
	task send(input logic [7:0] op, input logic [15:0] d);
		logic [23:0] f;
		f = {d, op};
		frame_o = 1'b1;
		for (int i = 0; i < 24; i++)
		begin
			tdi_o = f[i];
			#62.5 tck_o = 1'b1;
			#62.5 tck_o = 1'b0;
		end
		frame_o = 1'b0;
		tdi_o = ~f[23];
	endtask : send
endmodule : host_link

// ===== verif/tb_top.sv
// Self-checking bench for breakpoint compare and debug entry.
// Assumes the host model drives the link; core activity driven here.
`timescale 1ns/1ps
module tb_top;
	logic clk_i = 0, rstn_i = 0, tap_reset_i = 0, pc_valid_i = 0, daddr_valid_i = 0;
	logic dest_valid_i = 0, prefix_i = 0, instr_done_i = 0;
	logic [15:0] pc_i = 16'h0000, daddr_i = 16'h0000, wdata_i = 16'h0000;
	logic [8:0] dest_i = 9'h000;
	logic tck, tdi, frm, fetch_block_o, push_ret_o, ip_load_o, ige_clear_o, cpu_halt_o;
	logic timer_stop_o, irq_block_o, rd_valid_o;
	logic [1:0] status_o;
	logic [15:0] ip_value_o, rd_data_o;
	int errors = 0, comparisons = 0;
	int rd_seen = 0;
	always #5 clk_i = ~clk_i;
	// Counts read answer pulses; each read must give exactly one
	always @(posedge clk_i)
		if (rd_valid_o === 1'b1)
			rd_seen <= rd_seen + 1;
	host_link HOST (.tck_o(tck), .tdi_o(tdi), .frame_o(frm));
	bp_debug_entry DUT (.clk_i(clk_i), .rstn_i(rstn_i), .tck_i(tck), .tdi_i(tdi),
		.frame_i(frm), .tap_reset_i(tap_reset_i), .pc_i(pc_i), .pc_valid_i(pc_valid_i),
		.daddr_i(daddr_i), .daddr_valid_i(daddr_valid_i), .dest_i(dest_i),
		.wdata_i(wdata_i), .dest_valid_i(dest_valid_i), .prefix_i(prefix_i),
		.instr_done_i(instr_done_i), .fetch_block_o(fetch_block_o),
		.push_ret_o(push_ret_o), .ip_load_o(ip_load_o), .ip_value_o(ip_value_o),
		.ige_clear_o(ige_clear_o), .cpu_halt_o(cpu_halt_o), .timer_stop_o(timer_stop_o),
		.irq_block_o(irq_block_o), .status_o(status_o), .rd_data_o(rd_data_o),
		.rd_valid_o(rd_valid_o));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task step;
		@(posedge clk_i);
		#1;
	endtask : step
	// Long settle: command answer lands a few clocks after the last rising link edge
	task cmd(input logic [7:0] op, input logic [15:0] d);
		HOST.send(op, d);
		repeat (8) @(posedge clk_i);
	endtask : cmd
	task rd(input logic [7:0] op, input logic [15:0] exp);
		int n;
		n = rd_seen;
		cmd(op, 16'h0000);
		chk(rd_data_o, exp);
		chk(16'(rd_seen - n), 16'h0001);
	endtask : rd
	task reset;
		@(posedge clk_i) rstn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (2) @(posedge clk_i);
	endtask : reset
	task hit(input logic [15:0] a, input logic [8:0] dst, input logic [15:0] w, input bit reg_w);
		@(posedge clk_i);
		daddr_i <= a;
		daddr_valid_i <= ~reg_w;
		dest_i <= dst;
		wdata_i <= w;
		dest_valid_i <= reg_w;
		@(posedge clk_i);
		daddr_valid_i <= 1'b0;
		dest_valid_i <= 1'b0;
	endtask : hit
	task done_pulse(input bit prefix_register);
		@(posedge clk_i);
		instr_done_i <= 1'b1;
		prefix_i <= prefix_register;
		@(posedge clk_i);
		instr_done_i <= 1'b0;
	endtask : done_pulse
	task entry(input bit exp, input bit prefix_register);
		done_pulse(prefix_register);
		if (prefix_register)
		begin
			repeat (6) step;
			chk(fetch_block_o, 1'b0);
			done_pulse(1'b0);
		end
		// Look after the edge so the first blocked cycle is not skipped
		#1;
		for (int i = 0; i < 8 && fetch_block_o !== 1'b1; i++) step;
		chk(fetch_block_o, exp);
		if (exp)
		begin
			step;
			chk(push_ret_o, 1'b1);
			step;
			chk(ip_load_o, 1'b1);
			chk(ip_value_o, bp_debug_pkg::DEBUG_ENTRY_ADDR);
			step;
			chk(ige_clear_o, 1'b1);
			step;
			chk({cpu_halt_o, timer_stop_o, irq_block_o}, 16'h0007);
		end
		chk(status_o, exp ? bp_debug_pkg::STATUS_DEBUG_IDLE : 2'h0);
	endtask : entry
	task t_regs;
		for (int i = 0; i < 6; i++) rd(bp_debug_pkg::OP_READ_BP0 + 8'(i), 16'hFFFF);
		cmd(8'h19, 16'h1234);
		cmd(8'h1A, 16'hA5C3);
		rd(8'h09, 16'h1234);
		rd(8'h0A, 16'hA5C3);
		@(posedge clk_i) tap_reset_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		tap_reset_i <= 1'b0;
		rd(8'h09, 16'hFFFF);
		rd(8'h0A, 16'hFFFF);
	endtask : t_regs
	task t_addr(input bit en, input bit prefix_register);
		cmd(8'h19, 16'h0040);
		cmd(bp_debug_pkg::OP_WRITE_CTRL, {15'h0000, en});
		@(posedge clk_i) prefix_i <= prefix_register;
		hit(16'h0040, 9'h000, 16'h0000, 1'b0);
		entry(en, prefix_register);
		reset;
	endtask : t_addr
	// Data and mask reprogrammed every time, as the host must before resuming
	task t_reg(input logic [15:0] msk, input logic [15:0] w, input bit exp);
		cmd(8'h1A, 16'hFEA3);
		cmd(bp_debug_pkg::OP_WRITE_DATA, 16'h00F0);
		cmd(bp_debug_pkg::OP_WRITE_MASK, msk);
		cmd(bp_debug_pkg::OP_WRITE_CTRL, 16'h0003);
		rd(bp_debug_pkg::OP_READ_MASK, msk);
		rd(bp_debug_pkg::OP_READ_DATA, 16'h00F0);
		rd(bp_debug_pkg::OP_READ_CTRL, 16'h0003);
		hit(16'hFEA3, 9'h0A3, w, 1'b1);
		entry(exp, 1'b0);
		reset;
	endtask : t_reg
	task t_pc;
		cmd(bp_debug_pkg::OP_WRITE_BP0 + 8'h02, 16'h0123);
		cmd(bp_debug_pkg::OP_WRITE_CTRL, 16'h0001);
		@(posedge clk_i);
		pc_i <= 16'h0123;
		pc_valid_i <= 1'b1;
		@(posedge clk_i);
		pc_valid_i <= 1'b0;
		entry(1'b1, 1'b0);
		reset;
	endtask : t_pc
	task t_host;
		cmd(bp_debug_pkg::OP_DEBUG, 16'h0000);
		entry(1'b1, 1'b0);
		// Arm a real match so the ignored hit is not trivially absent
		cmd(8'h19, 16'h0040);
		cmd(bp_debug_pkg::OP_WRITE_CTRL, 16'h0001);
		cmd(bp_debug_pkg::OP_DEBUG, 16'h0000);
		hit(16'h0040, 9'h000, 16'h0000, 1'b0);
		step;
		chk({cpu_halt_o, status_o}, 16'h0005);
		chk({fetch_block_o, push_ret_o, ip_load_o, ige_clear_o}, 16'h0000);
		reset;
	endtask : t_host
	task print_verdict;
		if (errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict
	initial
	begin
		#900000;
		errors++;
		print_verdict;
	end
	initial
	begin
		repeat (20) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		t_regs;
		t_addr(1'b0, 1'b0);
		t_addr(1'b1, 1'b0);
		t_addr(1'b1, 1'b1);
		t_reg(16'h00FF, 16'h0011, 1'b0);
		t_reg(16'h00FF, 16'h12F0, 1'b1);
		t_reg(16'h0000, 16'hBEEF, 1'b1);
		t_pc;
		t_host;
		print_verdict;
	end
endmodule : tb_top
